//--- core/pps_sequencer.sv
// Purpose: power-up/power-down state machine with host reset and wake sources
// Assumes: comparator inputs are clean digital levels synchronous to ref_clk
// Notes: battery under 2.1V has priority over every other condition
`timescale 1ns/10ps
module pps_sequencer #(
    parameter int unsigned CYC_PER_MS = pps_pkg::CYCLES_PER_MS
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic batteryBelow2v1,
    input wire logic batteryAtLeast3v0,
    input wire logic batteryBelowLockout,
    input wire logic primaryAtLeast93,
    input wire logic primaryBelow85,
    input wire logic powerKey,
    input wire logic handsfreePowerIn,
    input wire logic alarmIn,
    input wire logic chargerSupplyIn,
    input wire logic chargerValid,
    input wire logic comparator1Out,
    input wire logic comparator2Out,
    input wire logic converterBusy,
    input wire logic hostKeepalive,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic hostResetN,
    output logic [2:0] seqRegulatorEn,
    output logic undervoltageLockoutEn,
    output logic backupChargerEn,
    output logic clockBackupRegulatorEn,
    output logic [12:0] termVoltMv,
    output logic [12:0] rechargeVoltMv,
    output logic [1:0] eocSel,
    output logic [8:0] seqState
);
    typedef struct packed {
        pps_pkg::pps_state_t state;
        logic regsOff;
        logic resetN;
        logic [2:0] regEn;
        logic undervoltage_lockout;
        logic backupChg;
        logic clkBackup;
        logic [3:0] wakePrev;
        logic [7:0] reason;
        logic [7:0] status;
    } pps_seq_st_t;

    pps_seq_st_t s_q;
    pps_seq_st_t s_d;

    logic [7:0] msCount;
    logic timerRestart;
    logic clkBackupOff;
    logic [3:0] wakeNow;
    logic [3:0] wakeEdge;
    logic [3:0] startupReason;
    logic anyWake;
    logic extSupply;

    // restart the timebase on every state change and while keepalive is high in idle
    assign timerRestart = (s_d.state != s_q.state)
        || (s_q.state == pps_pkg::PPS_IDLE && hostKeepalive);

    pps_ms_timebase #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timebase (
        .ref_clk(ref_clk),
        .srst(srst),
        .restart(timerRestart),
        .msCount(msCount)
    );

    pps_reg_file u_regs (
        .ref_clk(ref_clk),
        .srst(srst),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regWrData(regWrData),
        .reasonBits(s_q.reason),
        .statusBits(s_q.status),
        .regRdData(regRdData),
        .clkBackupOff(clkBackupOff),
        .termVoltMv(termVoltMv),
        .rechargeVoltMv(rechargeVoltMv),
        .eocSel(eocSel)
    );

    always_comb begin
        wakeNow = '0;
        wakeNow[pps_pkg::WAKE_KEY] = powerKey;
        wakeNow[pps_pkg::WAKE_HANDSFREE] = handsfreePowerIn;
        wakeNow[pps_pkg::WAKE_ALARM] = alarmIn;
        wakeNow[pps_pkg::WAKE_CHARGER] = chargerSupplyIn;
    end

    // wakes count on rising edges so a supply left plugged in does not re-wake
    assign wakeEdge = wakeNow & ~s_q.wakePrev;
    assign anyWake = |wakeEdge;
    assign extSupply = chargerSupplyIn || handsfreePowerIn;

    // charger bit records the pin level at start-up, others the wake edges
    always_comb begin
        startupReason = wakeEdge;
        startupReason[pps_pkg::WAKE_CHARGER] = chargerSupplyIn;
    end

    always_comb begin
        s_d = s_q;
        s_d.wakePrev = wakeNow;

        // live view of inputs, comparators and converter
        s_d.status = {1'b0, converterBusy, comparator2Out, comparator1Out,
            chargerValid, alarmIn, handsfreePowerIn, powerKey};

        unique case (s_q.state)
            pps_pkg::PPS_OFF: begin
                if (extSupply) begin
                    s_d.state = pps_pkg::PPS_EXT_STANDBY;
                end else if (batteryAtLeast3v0) begin
                    s_d.state = pps_pkg::PPS_STANDBY;
                end
            end
            pps_pkg::PPS_EXT_STANDBY: begin
                if (batteryAtLeast3v0) begin
                    s_d.state = pps_pkg::PPS_TURNON;
                    s_d.reason = {4'h0, startupReason | (wakeNow
                        & 4'(1 << pps_pkg::WAKE_HANDSFREE))};
                end
            end
            pps_pkg::PPS_STANDBY: begin
                if (anyWake) begin
                    s_d.state = pps_pkg::PPS_TURNON;
                    s_d.reason = {4'h0, startupReason};
                end
            end
            pps_pkg::PPS_TURNON: begin
                if (primaryAtLeast93) begin
                    s_d.state = pps_pkg::PPS_RESET_DELAY;
                end else if (msCount >= pps_pkg::TURNON_MS) begin
                    s_d.state = pps_pkg::PPS_STANDBY;
                end
            end
            pps_pkg::PPS_RESET_DELAY: begin
                if (batteryBelowLockout) begin
                    s_d.state = pps_pkg::PPS_SHUTDOWN;
                end else if (primaryBelow85) begin
                    s_d.state = pps_pkg::PPS_RECOVER;
                end else if (msCount >= pps_pkg::RESET_DELAY_MS) begin
                    s_d.state = pps_pkg::PPS_HOLD_DETECT;
                end
            end
            pps_pkg::PPS_HOLD_DETECT: begin
                if (batteryBelowLockout) begin
                    s_d.state = pps_pkg::PPS_SHUTDOWN;
                end else if (primaryBelow85) begin
                    s_d.state = pps_pkg::PPS_RECOVER;
                end else if (hostKeepalive) begin
                    s_d.state = pps_pkg::PPS_IDLE;
                end else if (msCount >= pps_pkg::HOLD_WAIT_MS) begin
                    s_d.state = pps_pkg::PPS_SHUTDOWN;
                end
            end
            pps_pkg::PPS_IDLE: begin
                // lockout and wake inputs are ignored here
                if (primaryBelow85) begin
                    s_d.state = pps_pkg::PPS_RECOVER;
                end else if (msCount > pps_pkg::HOLD_WAIT_MS) begin
                    s_d.state = pps_pkg::PPS_SHUTDOWN;
                end
            end
            pps_pkg::PPS_RECOVER: begin
                if (primaryAtLeast93) begin
                    s_d.state = pps_pkg::PPS_RESET_DELAY;
                end else if (msCount >= pps_pkg::RECOVER_MS) begin
                    s_d.state = pps_pkg::PPS_SHUTDOWN;
                end
            end
            pps_pkg::PPS_SHUTDOWN: begin
                if (msCount >= pps_pkg::REG_OFF_MS) begin
                    s_d.regsOff = 1'b1;
                end
                if (s_q.regsOff && primaryBelow85) begin
                    s_d.state = pps_pkg::PPS_STANDBY;
                end
            end
            default: begin
                s_d.state = pps_pkg::PPS_OFF;
            end
        endcase

        if (batteryBelow2v1) begin
            s_d.state = pps_pkg::PPS_OFF;
        end
        if (s_d.state != pps_pkg::PPS_SHUTDOWN) begin
            s_d.regsOff = 1'b0;
        end

        // outputs follow the next state so they change with it
        s_d.resetN = 1'b0;
        s_d.regEn = 3'h0;
        s_d.undervoltage_lockout = 1'b1;
        s_d.backupChg = 1'b0;
        unique case (s_d.state)
            pps_pkg::PPS_OFF, pps_pkg::PPS_EXT_STANDBY: begin
                s_d.undervoltage_lockout = 1'b1;
            end
            pps_pkg::PPS_STANDBY: begin
                s_d.backupChg = 1'b1;
            end
            pps_pkg::PPS_TURNON, pps_pkg::PPS_RESET_DELAY, pps_pkg::PPS_RECOVER: begin
                s_d.regEn = 3'h7;
            end
            pps_pkg::PPS_HOLD_DETECT: begin
                s_d.regEn = 3'h7;
                s_d.resetN = 1'b1;
            end
            pps_pkg::PPS_IDLE: begin
                s_d.regEn = 3'h7;
                s_d.resetN = 1'b1;
                s_d.undervoltage_lockout = 1'b0;
                s_d.backupChg = 1'b1;
            end
            pps_pkg::PPS_SHUTDOWN: begin
                s_d.regEn = s_d.regsOff ? 3'h0 : 3'h7;
                s_d.backupChg = 1'b1;
            end
            default: begin
                s_d.regEn = 3'h0;
            end
        endcase
        s_d.clkBackup = ~clkBackupOff;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q.state <= pps_pkg::PPS_OFF;
            s_q.regsOff <= 1'b0;
            s_q.resetN <= 1'b0;
            s_q.regEn <= 3'h0;
            s_q.undervoltage_lockout <= 1'b1;
            s_q.backupChg <= 1'b0;
            s_q.clkBackup <= 1'b1;
            s_q.wakePrev <= 4'h0;
            s_q.reason <= 8'h00;
            s_q.status <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign hostResetN = s_q.resetN;
    assign seqRegulatorEn = s_q.regEn;
    assign undervoltageLockoutEn = s_q.undervoltage_lockout;
    assign backupChargerEn = s_q.backupChg;
    assign clockBackupRegulatorEn = s_q.clkBackup;
    assign seqState = s_q.state;
endmodule : pps_sequencer

//--- core/pps_pkg.sv
// Purpose: shared constants and types of the power-up/down sequencer
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes: all timed waits run from a one-millisecond timebase
// Overview of operation
// - battery under 2.1V forces powered-off state
// - external supply waits for 3.0V, then turn-on
// - 3.0V first gives standby, backup charger on
// - key, charger, handsfree, alarm wake from standby
// - turn-on enables 1,3,5; 93% or 60ms
// - reset delay 40ms, lockout shuts, 85% restarts
// - hold detect releases reset, 35ms for keepalive
// - idle shuts only after keepalive low >35ms
// - idle lockout off, backup charger on, 85% restarts
// - shutdown asserts reset, regulators off after 60ms
// - lockout, hold/recovery timeouts or keepalive loss trigger shutdown
// - 85% drop waits 90ms with reset low
// - reason register latched per power-up, all sources
// - live status shows inputs, comparators, converter
// - charger status is valid window, reason is level
// - clock backup regulator on unless software disables
// - termination 4.1V or 4.2V, recharge 200mV below
// - end-of-charge 20%, 15% or 10%, default 10%
// - byte writes leave read-only and unused bits alone
package pps_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned MS_PERIOD_NS = 1000000;
    localparam int unsigned CYCLES_PER_MS = MS_PERIOD_NS / CLK_PERIOD_NS;

    localparam logic [7:0] TURNON_MS = 8'h3C;
    localparam logic [7:0] RESET_DELAY_MS = 8'h28;
    localparam logic [7:0] HOLD_WAIT_MS = 8'h23;
    localparam logic [7:0] RECOVER_MS = 8'h5A;
    localparam logic [7:0] REG_OFF_MS = 8'h3C;

    localparam logic [7:0] ADDR_REASON = 8'h0D;
    localparam logic [7:0] ADDR_STATUS = 8'h2E;
    localparam logic [7:0] ADDR_CTRL = 8'h30;

    localparam int unsigned WAKE_KEY = 0;
    localparam int unsigned WAKE_HANDSFREE = 1;
    localparam int unsigned WAKE_ALARM = 2;
    localparam int unsigned WAKE_CHARGER = 3;

    localparam int unsigned CTRL_CLKBK_OFF = 0;
    localparam int unsigned CTRL_TERM_LOW = 1;
    localparam int unsigned CTRL_EOC_LSB = 2;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h0F;
    localparam logic [7:0] CTRL_RESET = 8'h04;

    localparam logic [1:0] EOC_10PCT = 2'h1;
    localparam logic [1:0] EOC_15PCT = 2'h2;
    localparam logic [1:0] EOC_20PCT = 2'h3;

    localparam logic [12:0] TERM_HIGH_MV = 13'h1068;
    localparam logic [12:0] TERM_LOW_MV = 13'h1004;
    localparam logic [12:0] RECHARGE_GAP_MV = 13'h00C8;

    typedef enum logic [8:0] {
        PPS_OFF = 9'h001,
        PPS_EXT_STANDBY = 9'h002,
        PPS_STANDBY = 9'h004,
        PPS_TURNON = 9'h008,
        PPS_RESET_DELAY = 9'h010,
        PPS_HOLD_DETECT = 9'h020,
        PPS_IDLE = 9'h040,
        PPS_RECOVER = 9'h080,
        PPS_SHUTDOWN = 9'h100
    } pps_state_t;
endpackage : pps_pkg

//--- core/pps_ms_timebase.sv
// Purpose: millisecond timebase with restart and saturating ms count
// Assumes: restart is sampled on the same edge as the state change
// Notes: msCount reads N once at least N whole ms passed since restart
`timescale 1ns/10ps
module pps_ms_timebase #(
    parameter int unsigned CYC_PER_MS = pps_pkg::CYCLES_PER_MS
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic restart,
    output logic [7:0] msCount
);
    localparam int unsigned CW = $clog2(CYC_PER_MS + 1);

    typedef struct packed {
        logic [CW-1:0] cyc;
        logic [7:0] ms;
    } pps_tb_st_t;

    pps_tb_st_t s_q;
    pps_tb_st_t s_d;

    always_comb begin
        s_d = s_q;
        if (restart) begin
            s_d.cyc = '0;
            s_d.ms = 8'h00;
        end else if (s_q.cyc == CW'(CYC_PER_MS - 1)) begin
            s_d.cyc = '0;
            if (s_q.ms != 8'hFF) begin
                s_d.ms = s_q.ms + 8'h01;
            end
        end else begin
            s_d.cyc = s_q.cyc + CW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign msCount = s_q.ms;
endmodule : pps_ms_timebase

//--- core/pps_reg_file.sv
// Purpose: reason, live status and charger control registers
// Assumes: byte-wide register port from the serial interface engine
// Notes: read data is registered, one cycle after the address
`timescale 1ns/10ps
module pps_reg_file (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] reasonBits,
    input wire logic [7:0] statusBits,
    output logic [7:0] regRdData,
    output logic clkBackupOff,
    output logic [12:0] termVoltMv,
    output logic [12:0] rechargeVoltMv,
    output logic [1:0] eocSel
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rd;
        logic [12:0] term;
        logic [12:0] rech;
    } pps_rf_st_t;

    pps_rf_st_t s_q;
    pps_rf_st_t s_d;

    always_comb begin
        s_d = s_q;
        if (regWrEn && regAddr == pps_pkg::ADDR_CTRL) begin
            s_d.ctrl = (regWrData & pps_pkg::CTRL_WRITE_MASK)
                | (s_q.ctrl & ~pps_pkg::CTRL_WRITE_MASK);
            // code zero is not an end-of-charge level, keep the old one
            if (regWrData[pps_pkg::CTRL_EOC_LSB +: 2] == 2'h0) begin
                s_d.ctrl[pps_pkg::CTRL_EOC_LSB +: 2] = s_q.ctrl[pps_pkg::CTRL_EOC_LSB +: 2];
            end
        end
        s_d.term = s_d.ctrl[pps_pkg::CTRL_TERM_LOW] ? pps_pkg::TERM_LOW_MV
            : pps_pkg::TERM_HIGH_MV;
        s_d.rech = s_d.term - pps_pkg::RECHARGE_GAP_MV;
        unique case (regAddr)
            pps_pkg::ADDR_REASON: s_d.rd = reasonBits;
            pps_pkg::ADDR_STATUS: s_d.rd = statusBits;
            pps_pkg::ADDR_CTRL: s_d.rd = s_q.ctrl;
            default: s_d.rd = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q.ctrl <= pps_pkg::CTRL_RESET;
            s_q.rd <= 8'h00;
            s_q.term <= pps_pkg::TERM_HIGH_MV;
            s_q.rech <= pps_pkg::TERM_HIGH_MV - pps_pkg::RECHARGE_GAP_MV;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdData = s_q.rd;
    assign clkBackupOff = s_q.ctrl[pps_pkg::CTRL_CLKBK_OFF];
    assign termVoltMv = s_q.term;
    assign rechargeVoltMv = s_q.rech;
    assign eocSel = s_q.ctrl[pps_pkg::CTRL_EOC_LSB +: 2];
endmodule : pps_reg_file

//--- verification/pps_host_model.sv
// Purpose: host processor raising keepalive after its reset is released
// Assumes: raiseAfter counts cycles after release, 16'hFFFF never raises
// Notes: dropReq lowers keepalive while held; a host in reset drives it low
`timescale 1ns/10ps
module pps_host_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic hostResetN,
    input wire logic [15:0] raiseAfter,
    input wire logic dropReq,
    output logic hostKeepalive
);
    logic [15:0] upCnt_q;
    always_ff @(posedge ref_clk) begin
        if (srst || !hostResetN) begin
            upCnt_q <= 16'h0000;
            hostKeepalive <= 1'b0;
        end else begin
            if (upCnt_q != 16'hFFFF) begin
                upCnt_q <= upCnt_q + 16'h0001;
            end
            hostKeepalive <= !dropReq && (upCnt_q > raiseAfter);
        end
    end
endmodule : pps_host_model

//--- verification/pps_sequencer_properties.sv
// Purpose: port assertions of the power sequencer
// Assumes: CYC_PER_MS equals that of the bound instance
// Notes: dwell counts cycles since state entry, lowCnt_q keepalive-low cycles
`timescale 1ns/10ps
module pps_sequencer_properties #(
    parameter int unsigned CYC_PER_MS = 10
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic batteryBelow2v1,
    input wire logic batteryBelowLockout,
    input wire logic primaryAtLeast93,
    input wire logic primaryBelow85,
    input wire logic powerKey,
    input wire logic hostKeepalive,
    input wire logic hostResetN,
    input wire logic [2:0] seqRegulatorEn,
    input wire logic undervoltageLockoutEn,
    input wire logic backupChargerEn,
    input wire logic [8:0] seqState
);
    localparam int unsigned TON = 60 * CYC_PER_MS;
    localparam int unsigned TRD = 40 * CYC_PER_MS + 1;
    localparam int unsigned THD = 35 * CYC_PER_MS + 1;
    localparam int unsigned TREC = 90 * CYC_PER_MS + 1;
    localparam int unsigned TLOW = 35 * CYC_PER_MS - 2;
    logic [8:0] prevState_q;
    int unsigned dwell_q;
    int unsigned dwell;
    int unsigned lowCnt_q;
    assign dwell = (seqState != prevState_q) ? 0 : dwell_q + 1;
    always_ff @(posedge ref_clk) begin
        prevState_q <= srst ? 9'h001 : seqState;
        dwell_q <= srst ? 0 : dwell;
        lowCnt_q <= (srst || hostKeepalive) ? 0 : lowCnt_q + 1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence sReach93;
        seqState == 9'h008 && primaryAtLeast93 && !batteryBelow2v1;
    endsequence
    sequence sHoldOk;
        seqState == 9'h020 && hostKeepalive && !batteryBelow2v1 && !batteryBelowLockout
            && !primaryBelow85;
    endsequence
    off_forced_a: assert property (batteryBelow2v1 |=> seqState == 9'h001
        && undervoltageLockoutEn && seqRegulatorEn == 3'h0) else $error("not off on low battery");
    wake_key_a: assert property (seqState == 9'h004 && $rose(powerKey) && !batteryBelow2v1
        |=> seqState == 9'h008 && seqRegulatorEn == 3'h7) else $error("key did not wake");
    turnon_reach_a: assert property (sReach93 |=> seqState == 9'h010 && !hostResetN)
        else $error("no reset delay after 93 percent");
    turnon_bound_a: assert property (seqState == 9'h008 |-> dwell <= TON)
        else $error("turn-on overstayed");
    delay_bound_a: assert property (seqState == 9'h010 |-> dwell <= TRD && !hostResetN)
        else $error("reset delay wrong");
    hold_bound_a: assert property (seqState == 9'h020 |-> hostResetN && dwell <= THD)
        else $error("hold detect wrong");
    hold_release_a: assert property (sHoldOk |=> seqState == 9'h040 && hostResetN
        && !undervoltageLockoutEn && backupChargerEn) else $error("idle entry wrong");
    idle_short_a: assert property (seqState == 9'h040 && !primaryBelow85
        && !batteryBelow2v1 && lowCnt_q < TLOW |=> seqState == 9'h040)
        else $error("idle left early");
    recover_drop_a: assert property (seqState inside {9'h010, 9'h020, 9'h040}
        && primaryBelow85 && !batteryBelow2v1 && !batteryBelowLockout
        |=> seqState == 9'h080 && !hostResetN) else $error("no recovery on drop");
    recover_bound_a: assert property (seqState == 9'h080 |-> dwell <= TREC)
        else $error("recovery overstayed");
    shut_outputs_a: assert property (seqState == 9'h100 |-> !hostResetN
        && undervoltageLockoutEn && backupChargerEn && (dwell <= TON + 1
        || seqRegulatorEn == 3'h0)) else $error("shutdown outputs wrong");
endmodule : pps_sequencer_properties
bind pps_sequencer pps_sequencer_properties #(.CYC_PER_MS(CYC_PER_MS)) chkU (
    .ref_clk(ref_clk), .srst(srst), .batteryBelow2v1(batteryBelow2v1),
    .batteryBelowLockout(batteryBelowLockout), .primaryAtLeast93(primaryAtLeast93),
    .primaryBelow85(primaryBelow85), .powerKey(powerKey), .hostKeepalive(hostKeepalive),
    .hostResetN(hostResetN), .seqRegulatorEn(seqRegulatorEn),
    .undervoltageLockoutEn(undervoltageLockoutEn), .backupChargerEn(backupChargerEn),
    .seqState(seqState));

//--- verification/test_pps_sequencer.sv
// Purpose: self-checking bench of the power sequencer
// Assumes: one millisecond shortened to 10 clock cycles
// Notes: outs packs {hostResetN, regulators, lockout, backup charger, clock backup}
`timescale 1ns/10ps
module test_pps_sequencer;
    localparam int CPM = 10;
    logic ref_clk, srst, batteryBelow2v1, batteryAtLeast3v0, batteryBelowLockout;
    logic primaryAtLeast93, primaryBelow85, powerKey, handsfreePowerIn, alarmIn;
    logic chargerSupplyIn, chargerValid, comparator1Out, comparator2Out, converterBusy;
    logic hostKeepalive, regWrEn, dropReq, hostResetN, undervoltageLockoutEn;
    logic backupChargerEn, clockBackupRegulatorEn;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [2:0] seqRegulatorEn;
    logic [12:0] termVoltMv, rechargeVoltMv;
    logic [1:0] eocSel;
    logic [8:0] seqState;
    logic [15:0] raiseAfter;
    logic [6:0] outs;
    int numErrors = 0;
    int nTests = 0;
    int cycles = 0;
    assign outs = {hostResetN, seqRegulatorEn, undervoltageLockoutEn, backupChargerEn,
        clockBackupRegulatorEn};
    pps_sequencer #(.CYC_PER_MS(CPM)) dut_u (.ref_clk, .srst, .batteryBelow2v1,
        .batteryAtLeast3v0, .batteryBelowLockout, .primaryAtLeast93, .primaryBelow85,
        .powerKey, .handsfreePowerIn, .alarmIn, .chargerSupplyIn, .chargerValid,
        .comparator1Out, .comparator2Out, .converterBusy, .hostKeepalive, .regAddr,
        .regWrEn, .regWrData, .regRdData, .hostResetN, .seqRegulatorEn,
        .undervoltageLockoutEn, .backupChargerEn, .clockBackupRegulatorEn, .termVoltMv,
        .rechargeVoltMv, .eocSel, .seqState);
    pps_host_model hostModel_u (.ref_clk, .srst, .hostResetN, .raiseAfter, .dropReq,
        .hostKeepalive);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            numErrors++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic waitSt(input logic [8:0] exp, input int lim);
        for (int i = 0; i < lim && seqState !== exp; i++) tick(1);
        chk(16'(seqState), 16'(exp));
    endtask : waitSt
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        tick(1);
        chk(16'(regRdData), 16'(exp));
    endtask : rdChk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask : wr
    task automatic tReset;
        tick(1);
        chk(16'(seqState), 16'h0001);
        chk(16'(outs), 16'h0005);
        chk(16'({termVoltMv, eocSel}), 16'(15'h41A1));
        chk(16'(rechargeVoltMv), 16'h0FA0);
        $display("reset test done");
    endtask : tReset
    task automatic tRegs;
        wr(8'h30, 8'h0B);
        tick(2);
        chk(16'({termVoltMv, eocSel}), 16'(15'h4012));
        chk(16'(rechargeVoltMv), 16'h0F3C);
        chk(16'(clockBackupRegulatorEn), 16'h0000);
        rdChk(8'h30, 8'h0B);
        wr(8'h30, 8'h0C);
        tick(2);
        chk(16'({termVoltMv, eocSel, clockBackupRegulatorEn}), 16'h8347);
        wr(8'h30, 8'hF4);
        rdChk(8'h30, 8'h04);
        chk(16'(eocSel), 16'h0001);
        wr(8'h0D, 8'hFF);
        rdChk(8'h0D, 8'h00);
        rdChk(8'h55, 8'h00);
        $display("register test done");
    endtask : tRegs
    task automatic tExt;
        @(posedge ref_clk);
        chargerSupplyIn <= 1'b1;
        waitSt(9'h002, 3);
        chk(16'(undervoltageLockoutEn), 16'h0001);
        @(posedge ref_clk);
        batteryAtLeast3v0 <= 1'b1;
        waitSt(9'h008, 3);
        rdChk(8'h0D, 8'h08);
        tick(60 * CPM - 6);
        chk(16'(seqState), 16'h0008);
        waitSt(9'h004, 10);
        chk(16'(backupChargerEn), 16'h0001);
        @(posedge ref_clk);
        chargerSupplyIn <= 1'b0;
        $display("external supply test done");
    endtask : tExt
    task automatic tPower;
        @(posedge ref_clk);
        powerKey <= 1'b1;
        alarmIn <= 1'b1;
        waitSt(9'h008, 3);
        chk(16'({hostResetN, seqRegulatorEn}), 16'h0007);
        rdChk(8'h0D, 8'h05);
        @(posedge ref_clk);
        primaryAtLeast93 <= 1'b1;
        waitSt(9'h010, 3);
        tick(40 * CPM - 5);
        chk(16'(seqState), 16'h0010);
        waitSt(9'h020, 10);
        chk(16'(hostResetN), 16'h0001);
        waitSt(9'h040, 20);
        chk(16'(outs), 16'h007B);
        $display("power-up test done");
    endtask : tPower
    task automatic tIdle;
        @(posedge ref_clk);
        handsfreePowerIn <= 1'b1;
        chargerSupplyIn <= 1'b1;
        comparator2Out <= 1'b1;
        converterBusy <= 1'b1;
        rdChk(8'h2E, 8'h67);
        @(posedge ref_clk);
        chargerValid <= 1'b1;
        comparator1Out <= 1'b1;
        powerKey <= 1'b0;
        rdChk(8'h2E, 8'h7E);
        chk(16'(seqState), 16'h0040);
        rdChk(8'h0D, 8'h05);
        @(posedge ref_clk);
        {handsfreePowerIn, chargerSupplyIn, alarmIn, dropReq} <= 4'h1;
        tick(30 * CPM);
        @(posedge ref_clk);
        dropReq <= 1'b0;
        tick(5);
        chk(16'(seqState), 16'h0040);
        @(posedge ref_clk);
        dropReq <= 1'b1;
        tick(35 * CPM);
        chk(16'(seqState), 16'h0040);
        waitSt(9'h100, 3 * CPM);
        chk(16'({hostResetN, seqRegulatorEn}), 16'h0007);
        tick(60 * CPM - 5);
        chk(16'(seqRegulatorEn), 16'h0007);
        tick(10);
        chk(16'(seqRegulatorEn), 16'h0000);
        @(posedge ref_clk);
        {dropReq, primaryAtLeast93, primaryBelow85} <= 3'h1;
        waitSt(9'h004, 5);
        $display("idle test done");
    endtask : tIdle
    task automatic tFault;
        @(posedge ref_clk);
        raiseAfter <= 16'hFFFF;
        primaryBelow85 <= 1'b0;
        powerKey <= 1'b1;
        waitSt(9'h008, 3);
        @(posedge ref_clk);
        primaryAtLeast93 <= 1'b1;
        waitSt(9'h010, 3);
        @(posedge ref_clk);
        {primaryAtLeast93, primaryBelow85} <= 2'h1;
        waitSt(9'h080, 3);
        chk(16'(hostResetN), 16'h0000);
        tick(50);
        @(posedge ref_clk);
        {primaryAtLeast93, primaryBelow85} <= 2'h2;
        waitSt(9'h010, 3);
        waitSt(9'h020, 40 * CPM + 5);
        tick(35 * CPM - 5);
        chk(16'(seqState), 16'h0020);
        waitSt(9'h100, 10);
        @(posedge ref_clk);
        batteryBelow2v1 <= 1'b1;
        waitSt(9'h001, 3);
        @(posedge ref_clk);
        batteryBelow2v1 <= 1'b0;
        waitSt(9'h004, 3);
        chk(16'(backupChargerEn), 16'h0001);
        $display("fault test done");
    endtask : tFault
    initial begin
        {batteryBelow2v1, batteryAtLeast3v0, batteryBelowLockout, primaryAtLeast93} = 4'h0;
        {primaryBelow85, powerKey, handsfreePowerIn, alarmIn, chargerSupplyIn} = 5'h00;
        {chargerValid, comparator1Out, comparator2Out, converterBusy} = 4'h0;
        {regWrEn, dropReq} = 2'h0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        raiseAfter = 16'h0004;
        srst = 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        tReset();
        tRegs();
        tExt();
        tPower();
        tIdle();
        tFault();
        conclude();
    end
endmodule : test_pps_sequencer
